// >>> design/i2c_status_defines.svh
// Constants for the I2C master status and error flags
// Assumes inclusion by bare name from the package and the design modules
`ifndef I2C_STATUS_DEFINES_SVH
`define I2C_STATUS_DEFINES_SVH

// ------------------------------------------------------------
// Status codes
// ------------------------------------------------------------
`define TXN_IDLE        2'h0
`define TXN_BUSY        2'h1
`define TXN_ERROR       2'h2
`define TXN_DONE        2'h3

// ------------------------------------------------------------
// Widths and flag bit positions in the flag word
// ------------------------------------------------------------
`define STATE_W         2
`define REQ_W           8
`define FLAG_W          9
`define REJECT_BIT      8
`define ADDR_NACK_BIT   7
`define DATA_NACK_BIT   6

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define REQ_RESET       8'h00
`define FLAG_RESET      1'h0

`endif

// >>> design/i2c_status_pkg.sv
// Types shared by the I2C master status logic
// Assumes the constants header is on the include path
`include "i2c_status_defines.svh"

package i2c_status_pkg;
    typedef logic [`STATE_W-1:0] txn_state_t;
    typedef logic [`REQ_W-1:0]   req_word_t;
    typedef logic [`FLAG_W-1:0]  flag_word_t;
    typedef enum logic {PH_IDLE, PH_ACTIVE} phase_e;
endpackage

// >>> design/w0c_flag.sv
// One sticky error flag, cleared by writing 0, writes of 1 ignored
// Assumes a single clock and a synchronous active-low reset
`timescale 1ns/1ps
`include "i2c_status_defines.svh"

module w0c_flag (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic set,
    input  wire logic wr,
    input  wire logic wbit,
    output logic      flag
);
    logic flag_q;
    logic flag_d;

    // ------------------------------------------------------------
    // Next value, set wins over clear
    // ------------------------------------------------------------
    always_comb begin
        flag_d = flag_q;
        if (wr && !wbit) begin
            flag_d = 1'b0;              // [R4]
        end
        if (set) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            flag_q <= `FLAG_RESET;      // [R4]
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;
endmodule

// >>> design/i2c_master_status_flags.sv
// Status code, reject flag and acknowledge error flags of an I2C master
// Assumes the transaction engine reports ack slots and end of transaction
`timescale 1ns/1ps
`include "i2c_status_defines.svh"

// Contract
// R1: Two-bit status: 00 idle at reset, 01 busy, 10 error, 11 complete.
// R2: Status returns to 00 on zero writes or new launch; one writes ignored. The code loads 01, not 00, on a new launch.
// R3: Reject flag set by launch, protected write or data read while active.
// R4: Error flags reset to 0, cleared only by writing 0, ones ignored.
// R5: Address-unacked flag set when any slave address byte gets no acknowledge.
// R6: Combined read needs both address acknowledges; either missing flags error.
// R7: Byte-unacked flag set when a transmitted data byte is not acknowledged.
// R8: Request register writes ignored and contents kept while active.
// R9: Load 01 on start; on end load 10 if errors seen, else 11.
module i2c_master_status_flags
    import i2c_status_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      resetn,
    input  wire logic                      req_wr,
    input  wire i2c_status_pkg::req_word_t req_wdata,
    input  wire logic                      prot_wr,
    input  wire logic                      rx_byte_rd,
    input  wire logic                      state_wr,
    input  wire i2c_status_pkg::txn_state_t state_wdata,
    input  wire logic                      flag_wr,
    input  wire i2c_status_pkg::flag_word_t flag_wdata,
    input  wire logic                      addr_ack_slot,
    input  wire logic                      addr_acked,
    input  wire logic                      data_ack_slot,
    input  wire logic                      data_acked,
    input  wire logic                      engine_error,
    input  wire logic                      engine_done,
    output logic                           txn_start,
    output logic                           txn_active,
    output i2c_status_pkg::req_word_t      txn_request_reg,
    output i2c_status_pkg::txn_state_t     master_txn_state,
    output logic                           request_rejected_flag,
    output logic                           address_unacked_flag,
    output logic                           byte_unacked_flag
);
    import i2c_status_pkg::*;

    phase_e     phase_q;
    phase_e     phase_d;
    req_word_t  req_q;
    req_word_t  req_d;
    txn_state_t state_q;
    txn_state_t state_d;
    logic       err_q;
    logic       err_d;
    logic       launch;
    logic       finish;
    logic       reject_set;
    logic       addr_nack_set;
    logic       data_nack_set;
    logic       any_error;
    logic       active;

    // ------------------------------------------------------------
    // Missing acknowledge in an ack slot
    // ------------------------------------------------------------
    function automatic logic ack_missed(input logic slot, input logic acked);
        return slot && !acked;
    endfunction

    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    assign active        = (phase_q == PH_ACTIVE);
    assign launch        = req_wr && !active;                            // [R8]
    assign finish        = active && engine_done;
    assign reject_set    = active && (req_wr || prot_wr || rx_byte_rd);  // [R3]
    assign addr_nack_set = ack_missed(addr_ack_slot, addr_acked);        // [R5] [R6]
    assign data_nack_set = ack_missed(data_ack_slot, data_acked);        // [R7]
    assign any_error     = reject_set || addr_nack_set || data_nack_set || engine_error;

    // ------------------------------------------------------------
    // Transaction phase
    // ------------------------------------------------------------
    always_comb begin
        phase_d = phase_q;
        case (phase_q)
            PH_IDLE: begin
                if (launch) begin
                    phase_d = PH_ACTIVE;
                end
            end
            PH_ACTIVE: begin
                if (engine_done) begin
                    phase_d = PH_IDLE;
                end
            end
            default: begin
                phase_d = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            phase_q <= PH_IDLE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // ------------------------------------------------------------
    // Request register, kept while a transaction runs
    // ------------------------------------------------------------
    always_comb begin
        req_d = req_q;
        if (launch) begin
            req_d = req_wdata;                                           // [R8]
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            req_q <= `REQ_RESET;
        end else begin
            req_q <= req_d;
        end
    end

    // ------------------------------------------------------------
    // Error memory of the running transaction
    // ------------------------------------------------------------
    always_comb begin
        err_d = err_q;
        if (launch) begin
            err_d = `FLAG_RESET;
        end else if (active && any_error) begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            err_q <= `FLAG_RESET;
        end else begin
            err_q <= err_d;
        end
    end

    // ------------------------------------------------------------
    // Status code, start and end override a status write
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        if (state_wr) begin
            state_d = state_q & state_wdata;                             // [R2]
        end
        if (launch) begin
            state_d = `TXN_BUSY;                                         // [R2] [R9]
        end else if (finish) begin
            if (err_d) begin
                state_d = `TXN_ERROR;                                    // [R9]
            end else begin
                state_d = `TXN_DONE;                                     // [R9]
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_q <= `TXN_IDLE;                                        // [R1]
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Sticky error flags
    // ------------------------------------------------------------
    w0c_flag u_reject (
        .clock  (clock),
        .resetn (resetn),
        .set    (reject_set),
        .wr     (flag_wr),
        .wbit   (flag_wdata[`REJECT_BIT]),
        .flag   (request_rejected_flag)
    );

    w0c_flag u_addr_nack (
        .clock  (clock),
        .resetn (resetn),
        .set    (addr_nack_set),
        .wr     (flag_wr),
        .wbit   (flag_wdata[`ADDR_NACK_BIT]),
        .flag   (address_unacked_flag)
    );

    w0c_flag u_data_nack (
        .clock  (clock),
        .resetn (resetn),
        .set    (data_nack_set),
        .wr     (flag_wr),
        .wbit   (flag_wdata[`DATA_NACK_BIT]),
        .flag   (byte_unacked_flag)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign txn_start        = launch;
    assign txn_active       = active;
    assign txn_request_reg  = req_q;
    assign master_txn_state = state_q;                                   // [R1]
endmodule

// >>> dv/i2c_master_status_flags_props.sv
// Checker for the I2C master status and error flags
// Assumes binding to the top module and its single clock domain
`timescale 1ns/1ps
`include "i2c_status_defines.svh"
module i2c_status_props
    import i2c_status_pkg::*;
(
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic       req_wr,
    input wire req_word_t  req_wdata,
    input wire logic       prot_wr,
    input wire logic       rx_byte_rd,
    input wire logic       state_wr,
    input wire txn_state_t state_wdata,
    input wire logic       flag_wr,
    input wire flag_word_t flag_wdata,
    input wire logic       addr_ack_slot,
    input wire logic       addr_acked,
    input wire logic       data_ack_slot,
    input wire logic       data_acked,
    input wire logic       engine_done,
    input wire logic       txn_start,
    input wire logic       txn_active,
    input wire req_word_t  txn_request_reg,
    input wire txn_state_t master_txn_state,
    input wire logic       request_rejected_flag,
    input wire logic       address_unacked_flag,
    input wire logic       byte_unacked_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence launched;
        txn_active && master_txn_state == `TXN_BUSY;
    endsequence
    start_busy_a: assert property (req_wr && !txn_active |-> txn_start ##1 launched)
        else $error("launch not taken");
    refuse_req_a: assert property (req_wr && txn_active |-> !txn_start
        ##1 $stable(txn_request_reg) && request_rejected_flag)
        else $error("busy request not refused");
    load_req_a: assert property (txn_start |=> txn_request_reg == $past(req_wdata))
        else $error("request not loaded");
    reject_set_a: assert property (txn_active && (prot_wr || rx_byte_rd) |=> request_rejected_flag)
        else $error("reject flag missing");
    addr_nack_a: assert property (txn_active && addr_ack_slot && !addr_acked
        |=> address_unacked_flag)
        else $error("address nack missing");
    data_nack_a: assert property (txn_active && data_ack_slot && !data_acked |=> byte_unacked_flag)
        else $error("data nack missing");
    zero_clear_a: assert property (flag_wr && !flag_wdata[`DATA_NACK_BIT]
        && !(txn_active && data_ack_slot)
        |=> !byte_unacked_flag)
        else $error("flag not cleared");
    state_write_a: assert property (state_wr && !txn_active && !req_wr
        |=> master_txn_state == ($past(master_txn_state) & $past(state_wdata)))
        else $error("status write wrong");
    txn_end_a: assert property (txn_active && engine_done |=> !txn_active && master_txn_state[1])
        else $error("end status wrong");
endmodule
bind i2c_master_status_flags i2c_status_props u_props (.*);

// >>> dv/slave_ack_model.sv
// Model of the slaves answering acknowledge slots
// Assumes the bench commands each refusal through the nack inputs
`timescale 1ns/1ps
module slave_ack_model (
    input  wire logic clock,
    input  wire logic addr_ack_slot,
    input  wire logic data_ack_slot,
    input  wire logic nack_addr,
    input  wire logic nack_data,
    output logic      addr_acked,
    output logic      data_acked
);
    logic junk_q = 1'b0;
    always @(posedge clock) junk_q <= ~junk_q;
    // Ack only inside a slot, a toggling pattern outside
    assign addr_acked = addr_ack_slot ? !nack_addr : junk_q;
    assign data_acked = data_ack_slot ? !nack_data : junk_q;
endmodule

// >>> dv/test_i2c_master_status_flags.sv
// Testbench for the I2C master status and error flags
// Assumes the design, package and slave model are compiled first
`timescale 1ns/1ps
module test_i2c_master_status_flags;
    import i2c_status_pkg::*;
    logic clock = 0, resetn = 0, req_wr = 0, prot_wr = 0, rx_byte_rd = 0, state_wr = 0;
    logic flag_wr = 0, addr_ack_slot = 0, data_ack_slot = 0, engine_error = 0, engine_done = 0;
    logic nack_addr = 0, nack_data = 0, addr_acked, data_acked, txn_start, txn_active;
    logic request_rejected_flag, address_unacked_flag, byte_unacked_flag;
    req_word_t  req_wdata = 8'h00, txn_request_reg;
    txn_state_t state_wdata = 2'h0, master_txn_state;
    flag_word_t flag_wdata = 9'h000;
    int n_errors = 0, samples_checked = 0;
    i2c_master_status_flags u_dut (.*);
    slave_ack_model u_slave (.*);
    initial forever #25 clock = ~clock;
    task automatic cmp(string what, logic [8:0] exp, logic [8:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic flags(logic [2:0] exp);
        cmp("flags", {6'h00, exp}, {6'h00, request_rejected_flag, address_unacked_flag,
            byte_unacked_flag});
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        @(negedge clock);
        s = 0;
    endtask
    task automatic launch(req_word_t d);
        req_wdata = d;
        pulse(req_wr);
        cmp("state", 9'h001, {7'h00, master_txn_state});
        cmp("active", 9'h001, {8'h00, txn_active});
    endtask
    task automatic s_addr_reject();
        launch(8'hA5);
        req_wdata = 8'h3C;
        pulse(req_wr);
        cmp("request", 9'h0A5, {1'h0, txn_request_reg});
        flags(3'h4);
        pulse(addr_ack_slot);
        nack_addr = 1;
        pulse(addr_ack_slot);
        nack_addr = 0;
        flags(3'h6);
        pulse(engine_done);
        cmp("state", 9'h002, {7'h00, master_txn_state});
        cmp("active", 9'h000, {8'h00, txn_active});
        flag_wdata = 9'h1FF;
        pulse(flag_wr);
        flags(3'h6);
        flag_wdata = 9'h0BF;
        pulse(flag_wr);
        flags(3'h2);
        state_wdata = 2'h3;
        pulse(state_wr);
        cmp("state", 9'h002, {7'h00, master_txn_state});
        state_wdata = 2'h0;
        pulse(state_wr);
        cmp("state", 9'h000, {7'h00, master_txn_state});
    endtask
    task automatic s_data_nack();
        pulse(prot_wr);
        pulse(rx_byte_rd);
        flags(3'h2);
        launch(8'h5A);
        pulse(data_ack_slot);
        nack_data = 1;
        pulse(data_ack_slot);
        nack_data = 0;
        flags(3'h3);
        pulse(rx_byte_rd);
        flags(3'h7);
        pulse(engine_done);
        flag_wdata = 9'h000;
        pulse(flag_wr);
        flags(3'h0);
        launch(8'h01);
        pulse(engine_error);
        pulse(engine_done);
        cmp("state", 9'h002, {7'h00, master_txn_state});
        launch(8'hFF);
        pulse(addr_ack_slot);
        pulse(data_ack_slot);
        pulse(engine_done);
        cmp("state", 9'h003, {7'h00, master_txn_state});
    endtask
    task automatic summarize();
        if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clock);
        resetn = 1;
        cmp("state", 9'h000, {7'h00, master_txn_state});
        flags(3'h0);
        s_addr_reject();
        s_data_nack();
        summarize();
    end
endmodule
